/* oid_pkg.sv */
// constants, field layouts and state types for the optoisolated input debounce block
// assumes one 25 MHz clock and a nominal power-system frequency fixed at build time
`default_nettype none

package oid_pkg;

	// ****************************************************************
	// counts and timing
	// ****************************************************************
	localparam int         NUM_INPUTS           = 14;
	localparam int         MAIN_INPUTS          = 6;
	localparam int         CLK_HZ               = 25_000_000;
	localparam int         CLK_PERIOD_NS        = 40;
	localparam int         NOMINAL_HZ           = 60;
	localparam int         SAMPLES_PER_CYCLE    = 16;
	localparam int         SIXTEENTH_CLKS       = CLK_HZ / (NOMINAL_HZ * SAMPLES_PER_CYCLE);
	localparam int         SAMPLES_PER_INTERVAL = 4;
	localparam int         TB_DIV_W             = 20;
	localparam logic [4:0] AC_PICKUP_SAMPLES    = 5'h02;
	localparam logic [4:0] AC_DROPOUT_SAMPLES   = 5'h10;

	// ****************************************************************
	// debounce setting, hundredths of a cycle
	// ****************************************************************
	localparam logic [6:0] DEB_MAX_HUND   = 7'h64;
	localparam logic [6:0] DEB_RST_FIRST  = 7'h4B;
	localparam logic [6:0] DEB_RST_SECOND = 7'h64;
	localparam logic [6:0] DEB_RST_OTHER  = 7'h32;
	localparam int         DEB_HUND_LSB   = 0;
	localparam int         DEB_AC_BIT     = 8;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int         ADDR_W        = 8;
	localparam logic [7:0] REG_DEB_BASE  = 8'h00;
	localparam logic [7:0] REG_CTRL      = 8'h40;
	localparam logic [7:0] REG_PUBLISHED = 8'h44;
	localparam logic [7:0] REG_LIVE      = 8'h48;
	localparam logic [7:0] REG_FUNC      = 8'h4C;
	localparam int         CTRL_NC_BIT   = 0;
	localparam logic       CTRL_NC_RST   = 1'b0;

	// ****************************************************************
	// state types
	// ****************************************************************
	typedef struct packed {
		logic       ac;
		logic [6:0] hund;
	} oid_deb_set_type;

	typedef struct packed {
		logic       state;
		logic [4:0] cnt;
	} oid_cell_type;

	typedef struct packed {
		logic [TB_DIV_W-1:0] div;
		logic [1:0]          phase;
		logic                tick16;
		logic                quarter;
	} oid_tb_type;

	typedef struct packed {
		logic [NUM_INPUTS-1:0]                  sync1;
		logic [NUM_INPUTS-1:0]                  sync2;
		oid_deb_set_type [NUM_INPUTS-1:0]       set;
		logic                                   nc;
		logic [NUM_INPUTS-1:0]                  published;
		logic                                   breaker;
		logic                                   lockout;
		logic [31:0]                            rdata;
	} oid_top_type;

	// nearest sixteenth of a cycle: (h*16 + 50) / 100
	function automatic logic [4:0] oid_quantize(input logic [6:0] hund);
		logic [10:0] scaled;
		scaled = ({4'h0, hund} << 4) + 11'h032;
		return 5'(scaled / 11'h064);
	endfunction : oid_quantize

endpackage : oid_pkg

`default_nettype wire

/* oid_timebase.sv */
// sixteenth-cycle sample tick and quarter-cycle processing tick
// assumes the divider value fits TB_DIV_W bits and is at least two
`default_nettype none

module oid_timebase
	import oid_pkg::*;
#(
	parameter int SIXTEENTH_DIV = SIXTEENTH_CLKS
) (
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	output var  logic tick16_o,
	output var  logic quarter_o
);

	localparam logic [TB_DIV_W-1:0] DIV_LAST = TB_DIV_W'(SIXTEENTH_DIV - 1);

	oid_tb_type tb_r;
	oid_tb_type tb_nxt;

	// ****************************************************************
	// divider
	// ****************************************************************
	always_comb begin
		tb_nxt         = tb_r;
		tb_nxt.tick16  = 1'b0;
		tb_nxt.quarter = 1'b0;
		if (tb_r.div == DIV_LAST) begin
			tb_nxt.div     = '0;
			tb_nxt.tick16  = 1'b1;
			tb_nxt.phase   = 2'(tb_r.phase + 2'h1);
			tb_nxt.quarter = (tb_r.phase == 2'h3);
		end else begin
			tb_nxt.div = TB_DIV_W'(tb_r.div + 1'b1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tb_r <= '0;
		end else begin
			tb_r <= tb_nxt;
		end
	end

	assign tick16_o  = tb_r.tick16;
	assign quarter_o = tb_r.quarter;

	a_tick_period: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		tb_r.tick16 |-> tb_r.div == '0 && $past(tb_r.div) == DIV_LAST)
		else $error("sample tick off its period");

	a_quarter_aligned: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		tb_r.quarter |-> tb_r.tick16 && tb_r.phase == 2'h0)
		else $error("quarter tick not on every fourth sample tick");

endmodule : oid_timebase

`default_nettype wire

/* oid_debounce_cell.sv */
// one input's shared pickup/dropout timer, stepped once per sample tick
// assumes sample_i is already synchronised and qset_i is 0..16
`default_nettype none

module oid_debounce_cell
	import oid_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       tick16_i,
	input  wire logic       sample_i,
	input  wire logic       ac_i,
	input  wire logic [4:0] qset_i,
	output var  logic       state_o
);

	oid_cell_type c_r;
	oid_cell_type c_nxt;
	logic [4:0]   thresh;
	logic [4:0]   cnt_inc;

	// ****************************************************************
	// timer
	// ****************************************************************
	// one counter serves both directions: it counts samples that disagree with the state
	always_comb begin
		thresh  = ac_i ? (c_r.state ? AC_DROPOUT_SAMPLES : AC_PICKUP_SAMPLES) : qset_i;
		cnt_inc = 5'(c_r.cnt + 5'h01);
		c_nxt   = c_r;
		if (tick16_i) begin
			if (!ac_i && qset_i == 5'h00) begin
				c_nxt.state = sample_i;
				c_nxt.cnt   = 5'h00;
			end else if (sample_i == c_r.state) begin
				c_nxt.cnt = 5'h00;
			end else if (cnt_inc >= thresh) begin
				c_nxt.state = sample_i;
				c_nxt.cnt   = 5'h00;
			end else begin
				c_nxt.cnt = cnt_inc;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			c_r <= '0;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign state_o = c_r.state;

	a_only_on_tick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$changed(c_r.state) |-> $past(tick16_i))
		else $error("debounce state moved between sample ticks");

	a_zero_passthru: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		tick16_i && !ac_i && qset_i == 5'h00 |=> c_r.state == $past(sample_i))
		else $error("zero setting did not pass the sample");

	a_ac_pickup: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		tick16_i && ac_i && sample_i && !c_r.state && c_r.cnt == 5'h01 |=> c_r.state)
		else $error("ac pickup missed on second high sample");

	a_ac_dropout: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		tick16_i && ac_i && !sample_i && c_r.state |=>
		c_r.state == ($past(c_r.cnt) != 5'h0F))
		else $error("ac dropout not on sixteenth low sample");

	a_reversal_restart: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		tick16_i && sample_i == c_r.state |=> c_r.cnt == 5'h00 && $stable(c_r.state))
		else $error("agreeing sample did not restart the timer");

	a_timed_flip: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		tick16_i && !ac_i && qset_i != 5'h00 && sample_i != c_r.state |=>
		c_r.state == ($past(c_r.cnt) + 5'h01 >= $past(qset_i) ? $past(sample_i) : $past(c_r.state)))
		else $error("timed debounce flipped at the wrong count");

endmodule : oid_debounce_cell

`default_nettype wire

/* oid_input_debounce.sv */
// top of the optoisolated input conditioning: sync, debounce, publish, register port
// assumes raw_in_i are asynchronous pins; rd/wr strobes are single-cycle and never both high
//
// Design decisions made here: the address map and the address-and-strobe port.
`default_nettype none

module oid_input_debounce
	import oid_pkg::*;
#(
	parameter int SIXTEENTH_DIV = SIXTEENTH_CLKS
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic [NUM_INPUTS-1:0] raw_in_i,
	input  wire logic                  lockout_other_i,
	input  wire logic [ADDR_W-1:0]     addr_i,
	input  wire logic [31:0]           wr_data_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output var  logic [31:0]           rd_data_o,
	output var  logic [NUM_INPUTS-1:0] input_state_o,
	output var  logic                  first_input_state_o,
	output var  logic                  second_input_state_o,
	output var  logic                  breaker_closed_status_o,
	output var  logic                  reclose_lockout_drive_o
);

	oid_top_type           s_r;
	oid_top_type           s_nxt;
	logic                  tick16;
	logic                  quarter;
	logic [NUM_INPUTS-1:0] live;
	logic [4:0]            qset [NUM_INPUTS];
	logic [6:0]            hund_chk;

	// ****************************************************************
	// timebase
	// ****************************************************************
	oid_timebase #(
		.SIXTEENTH_DIV (SIXTEENTH_DIV)
	) u_timebase (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.tick16_o  (tick16),
		.quarter_o (quarter)
	);

	// ****************************************************************
	// per-input debounce
	// ****************************************************************
	for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_cell
		assign qset[g] = oid_quantize(s_r.set[g].hund);

		oid_debounce_cell u_cell (
			.clk_i    (clk_i),
			.rst_b_i  (rst_b_i),
			.tick16_i (tick16),
			.sample_i (s_r.sync2[g]),
			.ac_i     (s_r.set[g].ac),
			.qset_i   (qset[g]),
			.state_o  (live[g])
		);
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic [5:0] idx;
		logic [6:0] hund;
		idx   = addr_i[7:2];
		hund  = wr_data_i[DEB_HUND_LSB +: 7];
		s_nxt = s_r;
		// second stage only reads the first
		s_nxt.sync1 = raw_in_i;
		s_nxt.sync2 = s_r.sync1;

		// publishing samples the timers once per interval; short debounces wait for it
		if (quarter) begin
			s_nxt.published = live;
		end

		s_nxt.breaker = s_r.published[0] ^ s_r.nc;
		s_nxt.lockout = !s_r.published[1] || lockout_other_i;

		if (wr_i) begin
			if (addr_i[1:0] == 2'h0 && {2'h0, idx} < 8'(NUM_INPUTS)) begin
				s_nxt.set[idx[3:0]].ac   = wr_data_i[DEB_AC_BIT];
				// out-of-range times clamp to one cycle rather than wrap
				s_nxt.set[idx[3:0]].hund = (hund > DEB_MAX_HUND) ? DEB_MAX_HUND : hund;
			end else if (addr_i == REG_CTRL) begin
				s_nxt.nc = wr_data_i[CTRL_NC_BIT];
			end
		end

		s_nxt.rdata = 32'h0000_0000;
		if (rd_i) begin
			if (addr_i[1:0] == 2'h0 && {2'h0, idx} < 8'(NUM_INPUTS)) begin
				s_nxt.rdata[DEB_AC_BIT]         = s_r.set[idx[3:0]].ac;
				s_nxt.rdata[DEB_HUND_LSB +: 7]  = s_r.set[idx[3:0]].hund;
			end else begin
				case (addr_i)
					REG_CTRL: begin
						s_nxt.rdata[CTRL_NC_BIT] = s_r.nc;
					end
					REG_PUBLISHED: begin
						s_nxt.rdata[NUM_INPUTS-1:0] = s_r.published;
					end
					REG_LIVE: begin
						s_nxt.rdata[NUM_INPUTS-1:0] = live;
					end
					REG_FUNC: begin
						s_nxt.rdata[1:0] = {s_r.lockout, s_r.breaker};
					end
					default: begin
						s_nxt.rdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r       <= '0;
			s_r.nc    <= CTRL_NC_RST;
			s_r.lockout <= 1'b1;
			for (int k = 0; k < NUM_INPUTS; k++) begin
				s_r.set[k].hund <= DEB_RST_OTHER;
			end
			s_r.set[0].hund <= DEB_RST_FIRST;
			s_r.set[1].hund <= DEB_RST_SECOND;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_data_o               = s_r.rdata;
	assign input_state_o           = s_r.published;
	assign first_input_state_o     = s_r.published[0];
	assign second_input_state_o    = s_r.published[1];
	assign breaker_closed_status_o = s_r.breaker;
	assign reclose_lockout_drive_o = s_r.lockout;

	a_publish_quarter: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$changed(s_r.published) |-> $past(quarter) && s_r.published == $past(live))
		else $error("published bits changed off the processing interval");

	a_breaker_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		##1 breaker_closed_status_o == ($past(s_r.published[0]) ^ $past(s_r.nc)))
		else $error("breaker status does not follow first input");

	a_lockout_drive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		##1 reclose_lockout_drive_o == (!$past(s_r.published[1]) || $past(lockout_other_i)))
		else $error("lockout drive wrong for second input");

	a_setting_clamp: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wr_i && addr_i == REG_DEB_BASE |=>
		s_r.set[0].hund == ($past(hund_chk) > DEB_MAX_HUND ? DEB_MAX_HUND : $past(hund_chk)))
		else $error("debounce setting not stored or clamped");

	assign hund_chk = wr_data_i[DEB_HUND_LSB +: 7];

endmodule : oid_input_debounce

`default_nettype wire

/* oid_contact_model.sv */
// contacts and switches that apply control voltage to the raw inputs
// assumes the bench commands levels by non-blocking assignment after a rising edge
`default_nettype none

module oid_contact_model
	import oid_pkg::*;
(
	input  wire logic [NUM_INPUTS-1:0] close_i,
	input  wire logic [NUM_INPUTS-1:0] bounce_i,
	output var  logic [NUM_INPUTS-1:0] raw_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// contact level
	// ****************************************************************
	// a bouncing contact opens for as long as bounce is held
	assign raw_o = close_i & ~bounce_i;

endmodule : oid_contact_model

`default_nettype wire

/* tb_optoisolated_input_debounce.sv */
// self-checking bench: register port tasks, contact model, timed and ac debounce
// assumes a shortened sample divider of 4 clocks, so a quarter interval is 16 clocks
`default_nettype none

module tb_optoisolated_input_debounce;
	timeunit 1ns;
	timeprecision 1ns;
	import oid_pkg::*;

	localparam int DIV  = 4;
	localparam int QCLK = DIV * SAMPLES_PER_INTERVAL;
	// clocks after the zero-setting input, per input 0..7
	localparam int RISE [8] = '{32'h2C, 32'h3C, 32'h04, 32'h00, 32'h2C, 32'h30, 32'h3C, 32'h04};
	localparam int FALL [8] = '{32'h2C, 32'h3C, 32'h04, 32'h00, 32'h2C, 32'h30, 32'h3C, 32'h3C};
	localparam logic [31:0] SETS [8] = '{32'h4B, 32'h64, 32'h0D, 32'h00, 32'h4B, 32'h50, 32'h7F, 32'h100};

	logic                  clk_i, rst_b_i, lockout_other, wr, rd;
	logic [NUM_INPUTS-1:0] close, bounce, raw, pub, last_pub;
	logic [ADDR_W-1:0]     addr;
	logic [31:0]           wdata, rdata;
	logic                  first_st, second_st, breaker, lockout;
	int                    bad_count, n_checks, cyc, base, t_det [NUM_INPUTS];

	oid_contact_model contacts (.close_i(close), .bounce_i(bounce), .raw_o(raw));

	oid_input_debounce #(.SIXTEENTH_DIV(DIV)) uut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .raw_in_i(raw), .lockout_other_i(lockout_other),
		.addr_i(addr), .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata),
		.input_state_o(pub), .first_input_state_o(first_st), .second_input_state_o(second_st),
		.breaker_closed_status_o(breaker), .reclose_lockout_drive_o(lockout)
	);

	// ****************************************************************
	// clock, timeout, publish monitor
	// ****************************************************************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// published bits may only move on quarter-interval boundaries
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (rst_b_i === 1'b1 && pub !== last_pub) begin
			if (base >= 0) check(32'((cyc - base) % QCLK), 32'h0);
			else base = cyc;
			last_pub = pub;
		end
		if (cyc == 5000) begin
			bad_count++;
			complete_run();
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_i);
		wr    <= 1'b0;
	endtask : reg_wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_i);
		rd   <= 1'b0;
		#1 check(rdata, exp);
	endtask : rd_chk

	// move the masked contacts, then read live states every cycle and note when each bit follows
	task automatic poll(input logic [NUM_INPUTS-1:0] mask, input logic lvl);
		logic [NUM_INPUTS-1:0] seen;
		seen = '0;
		@(posedge clk_i);
		close <= lvl ? (close | mask) : (close & ~mask);
		addr  <= REG_LIVE;
		rd    <= 1'b1;
		for (int c = 0; c < 300 && seen !== mask; c++) begin
			@(posedge clk_i);
			#1;
			for (int i = 0; i < NUM_INPUTS; i++) begin
				if (mask[i] && !seen[i] && rdata[i] === lvl) begin
					seen[i]  = 1'b1;
					t_det[i] = c;
				end
			end
		end
		@(posedge clk_i);
		rd <= 1'b0;
		check({18'h0, seen}, {18'h0, mask});
	endtask : poll

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{rst_b_i, lockout_other, wr, rd} = 4'h0;
		close = '0;
		bounce = '0;
		addr = '0;
		wdata = '0;
		last_pub = '0;
		{bad_count, n_checks, cyc} = {32'h0, 32'h0, 32'h0};
		base = -1;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1 check({31'h0, lockout}, 32'h1);
		rd_chk(REG_DEB_BASE, 32'h4B);
		rd_chk(8'h04, 32'h64);
		reg_wr(REG_DEB_BASE, 32'h7F);
		rd_chk(REG_DEB_BASE, 32'h64);
		reg_wr(REG_DEB_BASE, 32'h4B);
		rd_chk(8'h80, 32'h0);
		reg_wr(REG_PUBLISHED, 32'h3FFF);
		rd_chk(REG_PUBLISHED, 32'h0);
		// mixed hundredths settings that cover rounding, zero and the clamp; the 0x100 input selects the special fast ac scheme
		for (int i = 2; i < 8; i++) reg_wr(8'(4 * i), SETS[i]);
		reg_wr(8'h20, 32'h4B);
		rd_chk(8'h18, 32'h64);
		rd_chk(8'h1C, 32'h100);
		poll(14'h00FF, 1'b1);
		for (int i = 0; i < 8; i++) check(32'(t_det[i] - t_det[3]), RISE[i]);
		check(32'(t_det[7] <= 48), 32'h1);
		repeat (2 * QCLK) @(posedge clk_i);
		#1 check({18'h0, pub}, 32'h00FF);
		check({30'h0, first_st, second_st}, 32'h3);
		check({30'h0, breaker, lockout}, 32'h2);
		rd_chk(REG_PUBLISHED, 32'h00FF);
		rd_chk(REG_FUNC, 32'h1);
		@(posedge clk_i);
		lockout_other <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1 check({31'h0, lockout}, 32'h1);
		@(posedge clk_i);
		lockout_other <= 1'b0;
		reg_wr(REG_CTRL, 32'h1);
		rd_chk(REG_CTRL, 32'h1);
		repeat (3) @(posedge clk_i);
		#1 check({31'h0, breaker}, 32'h0);
		reg_wr(REG_CTRL, 32'h0);
		poll(14'h00FF, 1'b0);
		for (int i = 0; i < 8; i++) check(32'(t_det[i] - t_det[3]), FALL[i]);
		check(32'(t_det[7] <= 80), 32'h1);
		repeat (2 * QCLK) @(posedge clk_i);
		#1 check({31'h0, lockout}, 32'h1);
		// a one-sample bounce mid-pickup must restart the 12-sample count
		fork
			poll(14'h0108, 1'b1);
			begin
				repeat (20) @(posedge clk_i);
				bounce[8] <= 1'b1;
				repeat (4) @(posedge clk_i);
				bounce[8] <= 1'b0;
			end
		join
		check(32'(t_det[8] - t_det[3] >= 60), 32'h1);
		// beyond one cycle the consumer must add its own timer on the published bit
		repeat (2 * QCLK) @(posedge clk_i);
		complete_run();
	end

endmodule : tb_optoisolated_input_debounce

`default_nettype wire
